// *** rtl/dgp_cfg.svh ***
/*
  register indices, reset values and field positions of the dual port block.
  assumes: byte address of a register is four times its index.
*/
`ifndef DGP_CFG_SVH
`define DGP_CFG_SVH

`define DGP_IDX_A_DATA   8'h05
`define DGP_IDX_B_DATA   8'h06
`define DGP_IDX_INTCTL   8'h0B
`define DGP_IDX_OPTION   8'h81
`define DGP_IDX_A_DIR    8'h85
`define DGP_IDX_B_DIR    8'h86
`define DGP_IDX_ANALOG   8'h9F

`define DGP_A_WIDTH      6
`define DGP_A_IMPL_BIG   6'h3F
`define DGP_A_IMPL_SMALL 6'h1F
`define DGP_A_DIR_RST    6'h3F
`define DGP_B_DIR_RST    8'hFF
`define DGP_OPTION_RST   8'hFF
`define DGP_ANALOG_RST   8'h00
`define DGP_LATCH_RST    8'h00

`define DGP_PULLUP_BIT   7
`define DGP_CHG_FLAG_BIT 0
`define DGP_TIMER_BIT    4
`define DGP_VREF_MSB     6
`define DGP_VREF_LSB     4
`define DGP_PINSEL_MSB   3
`define DGP_ANA_CHANNELS 7

`endif

// *** rtl/dgp_pkg.sv ***
/*
  types shared by the dual port block.
  assumes: dgp_cfg.svh holds the numbers.
*/
package dgp_pkg;

  typedef enum logic {
    DGP_BUS_IDLE,
    DGP_BUS_WDATA
  } dgp_bus_state_t;

  typedef struct packed {
    logic [7:0] idx;
    logic       mapped;
    logic       lane0;
  } dgp_xfer_t;

  typedef struct packed {
    logic timer_clock;
    logic ext_irq;
    logic slave_select;
    logic lowvolt_sense;
  } dgp_alt_t;

endpackage : dgp_pkg

// *** rtl/dgp_ports.sv ***
/*
  two general purpose ports with change detect, registers on ahb-lite.
  assumes: pins synchronous to ref_clk except the change-monitored four.
*/
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
`include "dgp_cfg.svh"
// Overview of operation
// - direction one makes pin input (driver off); zero drives latch onto pin.
// - first port has six bits on large package, five on small.
// - data read returns pin levels; data write updates latch, not pins.
// - every port write samples pins, modifies addressed bits, stores latch.
// - first port bit four feeds timer clock; open-drain output, others push-pull.
// - analog config register picks digital, analog or reference per pin.
// - after reset analog pins are analog and read as zero.
// - direction bits still drive analog pins; software keeps them one.
// - unimplemented port and direction bits read as zero.
// - first port direction resets to all ones in six bits.
// - second port is eight bits with same direction encoding.
// - option bit seven, when clear, enables second port pull-ups.
// - pull-up is off on any second port pin set as output.
// - pull-up control resets to one, so pull-ups start off.
// - second port pins carry irq, slave select, analog, low-volt inputs.
// - only input-configured pins seven to four join change compare.
// - mismatch against reference from last read or write sets change flag, bit zero.
// - change condition wakes the device from sleep.
// - mismatch keeps setting flag; port access ends it, then clear.
module dgp_ports
  import dgp_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [5:0]  pa_in,
  output logic      [5:0]  pa_out,
  output logic      [5:0]  pa_oe,
  input  wire logic [7:0]  pb_in,
  output logic      [7:0]  pb_out,
  output logic      [7:0]  pb_oe,
  output logic      [7:0]  pb_pullup,
  output logic      [5:0]  pa_analog,
  output logic      [7:0]  pb_analog,
  output dgp_alt_t         alt_in,
  input  wire logic        cpu_sleeping,
  output logic             wake_req,
  output logic             port_change_flag
);

  localparam logic [5:0] A_IMPL = LARGE_PKG ? `DGP_A_IMPL_BIG : `DGP_A_IMPL_SMALL;

  dgp_bus_state_t bus_state;
  dgp_xfer_t      xfer;
  dgp_xfer_t      next_xfer;
  logic [5:0]     a_latch;
  logic [7:0]     b_latch;
  logic [5:0]     a_dir;
  logic [7:0]     b_dir;
  logic [7:0]     option_control;
  logic [7:0]     analog_pin_config;
  logic [3:0]     chg_sync1;
  logic [3:0]     chg_sync2;
  logic [3:0]     chg_ref;
  logic           mismatch;
  logic           addr_ok;
  logic           rd_stall;
  logic           wr_now;
  logic           rd_now;
  logic [7:0]     wmask;
  logic [5:0]     a_rd;
  logic [7:0]     b_rd;
  logic [7:0]     next_rdata;
  logic [2:0]     ana_count;
  logic           vref_on;
  logic [6:0]     ch_analog;

  // bus front end
  assign addr_ok = hsel & htrans[1] & hready;
  // a read right behind a write waits one cycle so it sees the new value
  assign rd_stall = (bus_state == DGP_BUS_WDATA) & hsel & htrans[1] & ~hwrite;
  assign hreadyout = ~rd_stall;
  assign hresp = 1'b0;
  assign wr_now = (bus_state == DGP_BUS_WDATA);
  assign rd_now = addr_ok & ~hwrite;
  assign wmask = xfer.lane0 ? 8'hFF : 8'h00;

  always_comb begin
    next_xfer.idx = haddr[9:2];
    next_xfer.mapped = (haddr[31:10] == 22'h00_0000);
    next_xfer.lane0 = (haddr[1:0] == 2'h0);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_state <= DGP_BUS_IDLE;
      xfer <= '0;
    end else if (addr_ok && hwrite) begin
      bus_state <= DGP_BUS_WDATA;
      xfer <= next_xfer;
    end else begin
      bus_state <= DGP_BUS_IDLE;
    end
  end

  // analog pin selection
  assign ana_count = (analog_pin_config[`DGP_PINSEL_MSB:0] >= 4'h7) ? 3'h0 :
                     3'(4'h7 - analog_pin_config[`DGP_PINSEL_MSB:0]);
  assign vref_on = |analog_pin_config[`DGP_VREF_MSB:`DGP_VREF_LSB];

  genvar k;
  generate
    for (k = 0; k < `DGP_ANA_CHANNELS; k++) begin : g_chan
      assign ch_analog[k] = (3'(k) < ana_count) | (vref_on & ((k == 2) | (k == 3)));
    end
  endgenerate

  assign pa_analog = {ch_analog[4], 1'b0, ch_analog[3:0]} & A_IMPL;
  assign pb_analog = {4'h0, ch_analog[6:5], 2'h0};

  // pin reads: analog pins and absent bits show zero
  assign a_rd = pa_in & A_IMPL & ~pa_analog;
  assign b_rd = pb_in & ~pb_analog;

  always_comb begin
    next_rdata = 8'h00;
    if (next_xfer.mapped) begin
      unique case (next_xfer.idx)
        `DGP_IDX_A_DATA: next_rdata = {2'h0, a_rd};
        `DGP_IDX_B_DATA: next_rdata = b_rd;
        `DGP_IDX_INTCTL: next_rdata = {7'h00, port_change_flag};
        `DGP_IDX_OPTION: next_rdata = option_control;
        `DGP_IDX_A_DIR:  next_rdata = {2'h0, a_dir & A_IMPL};
        `DGP_IDX_B_DIR:  next_rdata = b_dir;
        `DGP_IDX_ANALOG: next_rdata = analog_pin_config;
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_now) begin
      hrdata <= {24'h00_0000, next_rdata};
    end
  end

  // register writes
  function automatic logic hit(input dgp_xfer_t x, input logic [7:0] idx);
    hit = x.mapped & (x.idx == idx);
  endfunction : hit

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      a_latch <= 6'(`DGP_LATCH_RST);
    end else if (wr_now && hit(xfer, `DGP_IDX_A_DATA)) begin
      a_latch <= ((a_rd & ~wmask[5:0]) | (hwdata[5:0] & wmask[5:0])) & A_IMPL;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      b_latch <= `DGP_LATCH_RST;
    end else if (wr_now && hit(xfer, `DGP_IDX_B_DATA)) begin
      b_latch <= (b_rd & ~wmask) | (hwdata[7:0] & wmask);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      a_dir <= `DGP_A_DIR_RST;
    end else if (wr_now && xfer.lane0 && hit(xfer, `DGP_IDX_A_DIR)) begin
      a_dir <= hwdata[5:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      b_dir <= `DGP_B_DIR_RST;
    end else if (wr_now && xfer.lane0 && hit(xfer, `DGP_IDX_B_DIR)) begin
      b_dir <= hwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      option_control <= `DGP_OPTION_RST;
    end else if (wr_now && xfer.lane0 && hit(xfer, `DGP_IDX_OPTION)) begin
      option_control <= hwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      analog_pin_config <= `DGP_ANALOG_RST;
    end else if (wr_now && xfer.lane0 && hit(xfer, `DGP_IDX_ANALOG)) begin
      analog_pin_config <= hwdata[7:0];
    end
  end

  // pin drivers; analog pins still follow their direction bits
  assign pa_out = {a_latch[5], 1'b0, a_latch[3:0]};
  always_comb begin
    pa_oe = ~a_dir & A_IMPL;
    pa_oe[`DGP_TIMER_BIT] = ~a_dir[`DGP_TIMER_BIT] & ~a_latch[`DGP_TIMER_BIT];
  end
  assign pb_out = b_latch;
  assign pb_oe = ~b_dir;
  assign pb_pullup = {8{~option_control[`DGP_PULLUP_BIT]}} & b_dir;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alt_in <= '0;
    end else begin
      alt_in.timer_clock <= pa_in[`DGP_TIMER_BIT];
      alt_in.ext_irq <= pb_in[0];
      alt_in.slave_select <= pb_in[1];
      alt_in.lowvolt_sense <= pb_in[3];
    end
  end

  // change detect; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chg_sync1 <= 4'h0;
      chg_sync2 <= 4'h0;
    end else begin
      chg_sync1 <= pb_in[7:4];
      chg_sync2 <= chg_sync1;
    end
  end

  // any read or write of the second port re-arms the reference
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chg_ref <= 4'h0;
    end else if ((rd_now && next_xfer.mapped && next_xfer.idx == `DGP_IDX_B_DATA) ||
                 (wr_now && hit(xfer, `DGP_IDX_B_DATA))) begin
      chg_ref <= chg_sync2;
    end
  end

  assign mismatch = |((chg_sync2 ^ chg_ref) & b_dir[7:4]);

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      port_change_flag <= 1'b0;
    end else if (wr_now && xfer.lane0 && hit(xfer, `DGP_IDX_INTCTL)) begin
      port_change_flag <= hwdata[`DGP_CHG_FLAG_BIT] | mismatch;
    end else begin
      port_change_flag <= port_change_flag | mismatch;
    end
  end

  assign wake_req = cpu_sleeping & (port_change_flag | mismatch);

  // checks
  chk_dir_reset_ones: assert property (@(posedge ref_clk)
    $past(rst) && !rst |-> a_dir == 6'h3F && b_dir == 8'hFF)
    else $error("direction not all ones after reset");
  chk_input_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (pa_oe & a_dir) == 6'h00 && (pb_oe & b_dir) == 8'h00)
    else $error("input pin is driven");
  chk_open_drain_low: assert property (@(posedge ref_clk) disable iff (rst)
    pa_oe[4] |-> !pa_out[4] && !a_latch[4] && !a_dir[4])
    else $error("open drain pin drives high");
  chk_pullup_gating: assert property (@(posedge ref_clk) disable iff (rst)
    pb_pullup == (b_dir & {8{!option_control[7]}}))
    else $error("pull-up on output or wrong control");
  chk_pullup_reset: assert property (@(posedge ref_clk)
    $past(rst) && !rst |-> pb_pullup == 8'h00)
    else $error("pull-ups on after reset");
  chk_read_pins: assert property (@(posedge ref_clk) disable iff (rst)
    rd_now && next_xfer.mapped && next_xfer.idx == 8'h06 |=> hrdata == {24'h00_0000, $past(b_rd)})
    else $error("port read is not pin level");
  chk_write_latch: assert property (@(posedge ref_clk) disable iff (rst)
    wr_now && xfer.lane0 && hit(xfer, 8'h06) |=> b_latch == $past(hwdata[7:0]) && pb_out == b_latch)
    else $error("port write did not reach latch");
  chk_unimpl_zero: assert property (@(posedge ref_clk) disable iff (rst)
    rd_now && next_xfer.idx == 8'h85 |=> hrdata[31:6] == 26'h000_0000)
    else $error("unimplemented bits not zero");
  chk_analog_reset: assert property (@(posedge ref_clk)
    $past(rst) && !rst |-> pa_analog == (6'h2F & A_IMPL) && pb_analog == 8'h0C
      && (pa_in & pa_analog & a_rd) == 6'h00)
    else $error("analog pins not analog after reset");
  chk_change_sets: assert property (@(posedge ref_clk) disable iff (rst)
    mismatch |=> port_change_flag)
    else $error("mismatch did not set flag");
  chk_output_excluded: assert property (@(posedge ref_clk) disable iff (rst)
    b_dir[7:4] == 4'h0 |-> !mismatch)
    else $error("output pin joined compare");
  chk_ref_rearm: assert property (@(posedge ref_clk) disable iff (rst)
    rd_now && next_xfer.mapped && next_xfer.idx == 8'h06 ##1 $stable(chg_sync2)
      |-> !mismatch)
    else $error("read did not end mismatch");
  chk_wake_up: assert property (@(posedge ref_clk) disable iff (rst)
    cpu_sleeping && port_change_flag |-> wake_req)
    else $error("no wake on change");

  // pin, control and change-detect checks beyond the basic set
  chk_no_wake_awake: assert property (@(posedge ref_clk) disable iff (rst)
    !cpu_sleeping |-> !wake_req)
    else $error("wake request while awake");
  chk_pullup_ctrl_off: assert property (@(posedge ref_clk) disable iff (rst)
    option_control[`DGP_PULLUP_BIT] |-> pb_pullup == 8'h00)
    else $error("pull-up on while control set");
  chk_pullup_on_input: assert property (@(posedge ref_clk) disable iff (rst)
    !option_control[`DGP_PULLUP_BIT] |-> pb_pullup == b_dir)
    else $error("pull-up missing on input pin");
  chk_dir_drives_pin: assert property (@(posedge ref_clk) disable iff (rst)
    (pb_oe | b_dir) == 8'hFF && ((pa_oe | a_dir | 6'h10) & A_IMPL) == A_IMPL)
    else $error("output pin not driven");
  chk_small_bit5: assert property (@(posedge ref_clk) disable iff (rst)
    !A_IMPL[5] |-> !pa_oe[5] && !pa_analog[5] && !a_rd[5])
    else $error("absent bit five is active");
  chk_analog_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (a_rd & pa_analog) == 6'h00 && (b_rd & pb_analog) == 8'h00)
    else $error("analog pin reads nonzero");
  chk_read_a_pins: assert property (@(posedge ref_clk) disable iff (rst)
    rd_now && next_xfer.mapped && next_xfer.idx == `DGP_IDX_A_DATA
      |=> hrdata == {26'h000_0000, $past(a_rd)})
    else $error("first port read is not pin level");
  chk_rmw_keep_pins: assert property (@(posedge ref_clk) disable iff (rst)
    wr_now && !xfer.lane0 && hit(xfer, `DGP_IDX_B_DATA) |=> b_latch == $past(b_rd))
    else $error("unmodified write did not store pins");
  chk_dir_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_now && xfer.lane0 && hit(xfer, `DGP_IDX_B_DIR) |=> b_dir == $past(hwdata[7:0]))
    else $error("direction write lost");
  chk_option_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_now && xfer.lane0 && hit(xfer, `DGP_IDX_OPTION)
      |=> option_control == $past(hwdata[7:0]))
    else $error("option write lost");
  chk_alt_follow: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) |-> alt_in.ext_irq == $past(pb_in[0])
      && alt_in.slave_select == $past(pb_in[1]) && alt_in.lowvolt_sense == $past(pb_in[3])
      && alt_in.timer_clock == $past(pa_in[4]))
    else $error("alternate input does not follow pin");
  chk_sync_two_flops: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) && !$past(rst, 2) |-> chg_sync2 == $past(pb_in[7:4], 2))
    else $error("monitored pins not two flops deep");
  chk_ref_on_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_now && hit(xfer, `DGP_IDX_B_DATA) |=> chg_ref == $past(chg_sync2))
    else $error("write did not re-arm reference");
  chk_flag_clears: assert property (@(posedge ref_clk) disable iff (rst)
    wr_now && xfer.lane0 && hit(xfer, `DGP_IDX_INTCTL) && !hwdata[`DGP_CHG_FLAG_BIT]
      && !mismatch |=> !port_change_flag)
    else $error("flag did not clear");
  chk_flag_holds: assert property (@(posedge ref_clk) disable iff (rst)
    port_change_flag && !(wr_now && xfer.lane0 && hit(xfer, `DGP_IDX_INTCTL))
      |=> port_change_flag)
    else $error("flag dropped without clear");

  cov_port_read: cover property (@(posedge ref_clk) disable iff (rst)
    rd_now && next_xfer.idx == 8'h06);
  cov_flag_set: cover property (@(posedge ref_clk) disable iff (rst)
    !port_change_flag ##1 port_change_flag);
  cov_read_stall: cover property (@(posedge ref_clk) disable iff (rst) rd_stall);
  cov_upper_lane_write: cover property (@(posedge ref_clk) disable iff (rst)
    wr_now && !xfer.lane0 && hit(xfer, 8'h05));
  cov_wake_req: cover property (@(posedge ref_clk) disable iff (rst)
    cpu_sleeping && wake_req);

endmodule : dgp_ports

// *** dv/dgp_board.sv ***
/*
  board-side model of the pins of both ports.
  assumes: tb sets board drive values and enables; device drive wins.
*/
`timescale 1ns/100ps
module dgp_board (
  input  wire logic       ref_clk,
  input  wire logic [5:0] pa_out,
  input  wire logic [5:0] pa_oe,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] pb_pullup,
  input  wire logic [5:0] drv_a,
  input  wire logic [5:0] en_a,
  input  wire logic [7:0] drv_b,
  input  wire logic [7:0] en_b,
  output logic      [5:0] pa_in,
  output logic      [7:0] pb_in
);
  logic [7:0] flt = 8'h55;
  // floating lines wander so no settled level is read
  always @(posedge ref_clk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pb_in[i] = pb_oe[i] ? pb_out[i] : en_b[i] ? drv_b[i] : pb_pullup[i] | flt[i];
    end
    for (int i = 0; i < 6; i++) begin
      pa_in[i] = pa_oe[i] ? pa_out[i] : en_a[i] ? drv_a[i] : flt[i];
    end
  end
endmodule : dgp_board

// *** dv/tb.sv ***
/*
  self-checking bench of the dual port block.
  assumes: one slave on ahb-lite, board model on the pins.
*/
`timescale 1ns/100ps
`include "dgp_cfg.svh"
module tb
  import dgp_pkg::*;
;
  logic        ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, cpu_sleeping = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        hreadyout, hresp, wake_req, port_change_flag;
  logic [5:0]  pa_in, pa_out, pa_oe, pa_analog, drv_a = 6'h3F, en_a = 6'h3F;
  logic [7:0]  pb_in, pb_out, pb_oe, pb_pullup, pb_analog, drv_b = 8'hA5, en_b = 8'hFF;
  logic [7:0]  rd;
  dgp_alt_t    alt_in;
  int          fail_count = 0, samples_checked = 0;

  dgp_ports dut_u (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pa_in, .pa_out, .pa_oe, .pb_in,
    .pb_out, .pb_oe, .pb_pullup, .pa_analog, .pb_analog, .alt_in, .cpu_sleeping,
    .wake_req, .port_change_flag);
  dgp_board board_u (.ref_clk, .pa_out, .pa_oe, .pb_out, .pb_oe, .pb_pullup, .drv_a,
    .en_a, .drv_b, .en_b, .pa_in, .pb_in);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // three idle cycles between transfers keep the driver off its own edge
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [7:0] wd);
    logic ok;
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= addr;
    hwrite <= wr;
    for (int ph = 0; ph < 2; ph++) begin
      ok = 1'b0;
      // ready is taken at the rising edge, before that edge's updates land
      for (int n = 0; n < 20 && !ok; n++) begin
        @(posedge ref_clk);
        ok = (hreadyout === 1'b1);
      end
      if (!ok) begin
        fail_count++;
        $display("unexpected hreadyout: expected 1, seen %b", hreadyout);
        complete_run();
      end
      if (ph == 0) begin
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
      end else begin
        rd = hrdata[7:0];
      end
    end
    // one more edge so the caller sees what the write just stored
    @(posedge ref_clk);
  endtask : bus

  function automatic logic [31:0] ad(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction : ad

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    bus(1'b1, ad(idx), val);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, ad(idx), 8'h00);
    check(what, exp, rd);
  endtask : rdchk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic reset_values();
    rdchk("a dir", `DGP_IDX_A_DIR, 8'h3F);
    rdchk("b dir", `DGP_IDX_B_DIR, 8'hFF);
    rdchk("option", `DGP_IDX_OPTION, 8'hFF);
    check("pullup", 8'h00, pb_pullup);
    check("hresp", 8'h00, {7'h0, hresp});
    rdchk("analog cfg", `DGP_IDX_ANALOG, 8'h00);
    rdchk("a pins", `DGP_IDX_A_DATA, 8'h10);
    rdchk("b pins", `DGP_IDX_B_DATA, 8'hA1);
    rdchk("unmapped", 8'h40, 8'h00);
    check("alt in", 8'h0C, {4'h0, alt_in});
  endtask : reset_values

  task automatic port_a_io();
    wr(`DGP_IDX_ANALOG, 8'h15);
    check("a analog ref", 8'h0F, {2'b00, pa_analog});
    wr(`DGP_IDX_ANALOG, 8'h01);
    check("a analog count", 8'h2F, {2'b00, pa_analog});
    check("b analog", 8'h04, pb_analog);
    wr(`DGP_IDX_ANALOG, 8'h07);
    drv_a <= 6'h2A;
    cyc(1);
    check("a analog", 8'h00, {2'b00, pa_analog});
    rdchk("a pins", `DGP_IDX_A_DATA, 8'h2A);
    wr(`DGP_IDX_A_DATA, 8'hFF);
    rdchk("a pins held", `DGP_IDX_A_DATA, 8'h2A);
    wr(`DGP_IDX_A_DIR, 8'h00);
    check("a oe", 8'h2F, {2'b00, pa_oe});
    check("a out", 8'h2F, {2'b00, pa_out});
    rdchk("a driven", `DGP_IDX_A_DATA, 8'h2F);
    wr(`DGP_IDX_A_DIR, 8'hFF);
    rdchk("a dir top", `DGP_IDX_A_DIR, 8'h3F);
    drv_a <= 6'h15;
    bus(1'b1, ad(`DGP_IDX_A_DATA) + 32'h1, 8'hFF);
    wr(`DGP_IDX_A_DIR, 8'h00);
    check("a rmw out", 8'h05, {2'b00, pa_out});
    check("a rmw oe", 8'h2F, {2'b00, pa_oe});
    wr(`DGP_IDX_A_DATA, 8'h00);
    check("a oe low", 8'h3F, {2'b00, pa_oe});
    rdchk("a low", `DGP_IDX_A_DATA, 8'h00);
  endtask : port_a_io

  task automatic port_b_io();
    wr(`DGP_IDX_B_DIR, 8'hF0);
    wr(`DGP_IDX_B_DATA, 8'h5A);
    check("b out", 8'h5A, pb_out);
    check("b oe", 8'h0F, pb_oe);
    wr(`DGP_IDX_OPTION, 8'h7F);
    check("pullup", 8'hF0, pb_pullup);
    rdchk("option", `DGP_IDX_OPTION, 8'h7F);
  endtask : port_b_io

  task automatic change_detect();
    rdchk("b pins", `DGP_IDX_B_DATA, 8'hAA);
    wr(`DGP_IDX_INTCTL, 8'h00);
    drv_b <= 8'h25;
    cpu_sleeping <= 1'b1;
    cyc(2);
    check("flag early", 8'h00, {7'h0, port_change_flag});
    cyc(1);
    check("flag", 8'h01, {7'h0, port_change_flag});
    check("wake", 8'h01, {7'h0, wake_req});
    wr(`DGP_IDX_INTCTL, 8'h00);
    check("flag held", 8'h01, {7'h0, port_change_flag});
    rdchk("b pins", `DGP_IDX_B_DATA, 8'h2A);
    wr(`DGP_IDX_INTCTL, 8'h00);
    cyc(2);
    check("flag clear", 8'h00, {7'h0, port_change_flag});
    check("no wake", 8'h00, {7'h0, wake_req});
    wr(`DGP_IDX_B_DIR, 8'h0F);
    wr(`DGP_IDX_B_DATA, 8'h00);
    cyc(6);
    check("outputs masked", 8'h00, {7'h0, port_change_flag});
    rdchk("intctl", `DGP_IDX_INTCTL, 8'h00);
  endtask : change_detect

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    reset_values();
    port_a_io();
    port_b_io();
    change_detect();
    complete_run();
  end
endmodule : tb
